// [mem_model.sv]
// Behavioural memory that answers the port's transfer requests.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_req,
   input  wire logic         i_write,
   input  wire logic [31:0]  i_addr,
   input  wire logic [2:0]   i_size,
   input  wire logic [31:0]  i_strb,
   input  wire logic [255:0] i_wdata,
   input  wire logic         i_slow,
   output logic              o_done,
   output logic      [255:0] o_rdata,
   output logic      [31:0]  o_count,
   output logic      [31:0]  o_addr,
   output logic      [2:0]   o_size,
   output logic      [31:0]  o_strb,
   output logic      [255:0] o_wdata,
   output logic              o_write
);
   logic [3:0] wait_q;
   // ==========================================================================
   // Waits out the latency, answers once, and keeps read data valid only then.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wait_q  <= 4'h0;
         o_done  <= 1'b0;
         o_rdata <= '0;
         o_count <= 32'h0;
      end else begin
         o_done  <= 1'b0;
         o_rdata <= ~o_rdata;
         if (i_req && !o_done && wait_q >= (i_slow ? 4'h6 : 4'h0)) begin
            wait_q  <= 4'h0;
            o_done  <= 1'b1;
            o_count <= o_count + 32'h1;
            o_addr  <= i_addr;
            o_size  <= i_size;
            o_strb  <= i_strb;
            o_wdata <= i_wdata;
            o_write <= i_write;
            for (int k = 0; k < 8; k++) begin
               o_rdata[32*k +: 32] <= i_addr + 32'(k) * 32'h0101_0101;
            end
         end else if (i_req && !o_done) begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [mem_port_pkg.sv]
// Constants shared by the memory access port data window and identification logic.
package mem_port_pkg;
   // ==========================================================================
   // Register offsets.
   localparam logic [11:0] OFS_CTRL  = 12'h000;
   localparam logic [11:0] OFS_XADDR = 12'h004;
   localparam logic [11:0] OFS_WIN   = 12'h00c;
   localparam logic [11:0] OFS_ARCH = 12'hfbc;
   localparam logic [11:0] OFS_CAP2 = 12'hfc0;
   localparam logic [11:0] OFS_CAP1 = 12'hfc4;
   localparam logic [11:0] OFS_CAPM = 12'hfcc;
   // ==========================================================================
   // Identification values; designer, revision and code values are arbitrary.
   localparam logic [10:0] ARCH_DESIGNER = 11'h155;
   localparam logic        ARCH_PRESENT  = 1'h1;
   localparam logic [3:0]  ARCH_REV      = 4'h3;
   localparam logic [15:0] ARCH_CODE     = 16'h5a5a;
   localparam int          ARCH_DES_LSB  = 21;
   localparam int          ARCH_PRES_BIT = 20;
   localparam int          ARCH_REV_LSB  = 16;
   localparam logic [3:0]  CLASS_SUB     = 4'h0;
   localparam logic [3:0]  CLASS_MAJOR   = 4'h0;
   localparam int          CLASS_SUB_LSB = 4;
   localparam logic [31:0] CAP_VALUE     = 32'h0000_0000;
   // ==========================================================================
   // Control word fields.
   localparam int          CTL_SIZE_LSB  = 0;
   localparam int          CTL_STEP_LSB  = 4;
   localparam logic [2:0]  CTL_SIZE_RST  = 3'h0;
   localparam logic [1:0]  CTL_STEP_RST  = 2'h0;
   localparam logic [1:0]  STEP_OFF      = 2'h0;
   localparam logic [2:0]  SZ_BYTE       = 3'h0;
   localparam logic [2:0]  SZ_HALF       = 3'h1;
   localparam logic [2:0]  SZ_WORD       = 3'h2;
   localparam logic [2:0]  SZ_256        = 3'h5;
   localparam logic        LARGE_DATA    = 1'h1;
   // ==========================================================================
   // Data widths.
   localparam int          WORDS         = 8;
   localparam int          WIDE_W        = 256;
endpackage

// [mem_port_window.sv]
// Data window, control word, address register and identification registers.
//
// Function
// - Identity register: designer bits, present flag.
// - Identity register: fixed revision and architecture code.
// - Main capability register reads all zero.
// - Two extended capability registers read zero.
// - Class register: sub and major, upper zero.
// - Class register reports undefined, miscellaneous encodings.
// - Data window access becomes memory transfer.
// - Window write value is memory write data.
// - Window read returns memory read data.
// - Access completes after its memory transfers.
// - Byte size uses one transfer, lane strobe.
// - Halfword or word: exactly one transfer.
// - Sizes above word up to 256 bits select multi-access sequence; larger codes fall back to word.
// - Wide transfer assembled from consecutive accesses.
// - Control word access abandons running sequence.
// - Abandoned write sequence issues no write.
// - Address advances per step setting after access.
// - Window register carries full 32-bit data.
// - Wide: first read fetches, last write stores.
`timescale 1ns/1ps
`default_nettype none
module mem_port_window (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_acc_req,
   input  wire logic         i_acc_write,
   input  wire logic [11:0]  i_acc_addr,
   input  wire logic [31:0]  i_acc_wdata,
   output logic              o_acc_done,
   output logic      [31:0]  o_acc_rdata,
   output logic              o_mem_req,
   output logic              o_mem_write,
   output logic      [31:0]  o_mem_addr,
   output logic      [2:0]   o_mem_size,
   output logic      [31:0]  o_mem_strb,
   output logic      [255:0] o_mem_wdata,
   input  wire logic         i_mem_done,
   input  wire logic [255:0] i_mem_rdata
);
   typedef enum logic [1:0] {S_IDLE, S_MEM, S_FETCH} fsm_type;

   typedef struct packed {
      fsm_type          st;
      logic [2:0]       ctl_size;
      logic [1:0]       ctl_step;
      logic [31:0]      xfer_addr;
      logic [2:0]       seq;
      logic [7:0][31:0] wdata;
      logic             mem_req;
      logic             mem_write;
      logic [31:0]      mem_addr;
      logic [2:0]       mem_size;
      logic [31:0]      mem_strb;
      logic             acc_done;
      logic [31:0]      acc_rdata;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic      take;
   logic      load;
   logic [31:0] rd_word;

   // ==========================================================================
   // Size helpers.
   function automatic logic [3:0] words_of(input logic [2:0] sz);
      words_of = (sz > mem_port_pkg::SZ_WORD) ?
                 4'(4'h1 << (sz - mem_port_pkg::SZ_WORD)) : 4'h1;
   endfunction

   function automatic logic [5:0] bytes_of(input logic [2:0] sz);
      bytes_of = 6'(6'h1 << sz);
   endfunction

   function automatic logic [31:0] lane_mask(input logic [2:0] sz, input logic [1:0] a);
      logic [32:0] m;
      m = (33'h1 << bytes_of(sz)) - 33'h1;
      if (sz < mem_port_pkg::SZ_WORD) begin
         m = m << a;
      end
      lane_mask = m[31:0];
   endfunction

   function automatic logic [2:0] legal_size(input logic [2:0] sz);
      if (sz > mem_port_pkg::SZ_256 ||
          (!mem_port_pkg::LARGE_DATA && sz > mem_port_pkg::SZ_WORD)) begin
         legal_size = mem_port_pkg::SZ_WORD;
      end else begin
         legal_size = sz;
      end
   endfunction

   assign take = i_acc_req && s_q.st == S_IDLE;
   assign load = s_q.st == S_MEM && i_mem_done && !s_q.mem_write;

   word_store u_store (
      .i_clk       (i_clk),
      .i_resetn    (i_resetn),
      .i_load      (load),
      .i_load_data (i_mem_rdata),
      .i_rd_idx    (s_q.seq),
      .o_rd_word   (rd_word)
   );

   // ==========================================================================
   // Access handling.
   always_comb begin
      logic [3:0] last;
      last = words_of(s_q.ctl_size) - 4'h1;
      s_d = s_q;
      s_d.acc_done = 1'b0;
      unique case (s_q.st)
         S_IDLE: begin
            if (take) begin
               s_d.acc_done  = 1'b1;
               s_d.acc_rdata = 32'h0;
               unique case (i_acc_addr)
                  mem_port_pkg::OFS_CTRL: begin
                     s_d.seq = 3'h0;
                     if (i_acc_write) begin
                        s_d.ctl_size = legal_size(i_acc_wdata[mem_port_pkg::CTL_SIZE_LSB +: 3]);
                        s_d.ctl_step = i_acc_wdata[mem_port_pkg::CTL_STEP_LSB +: 2];
                     end
                     s_d.acc_rdata[mem_port_pkg::CTL_SIZE_LSB +: 3] = s_q.ctl_size;
                     s_d.acc_rdata[mem_port_pkg::CTL_STEP_LSB +: 2] = s_q.ctl_step;
                  end
                  mem_port_pkg::OFS_XADDR: begin
                     if (i_acc_write) begin
                        s_d.xfer_addr = i_acc_wdata;
                     end
                     s_d.acc_rdata = s_q.xfer_addr;
                  end
                  mem_port_pkg::OFS_ARCH: begin
                     s_d.acc_rdata[31:mem_port_pkg::ARCH_DES_LSB] =
                        mem_port_pkg::ARCH_DESIGNER;
                     s_d.acc_rdata[mem_port_pkg::ARCH_PRES_BIT] =
                        mem_port_pkg::ARCH_PRESENT;
                     s_d.acc_rdata[mem_port_pkg::ARCH_REV_LSB +: 4] =
                        mem_port_pkg::ARCH_REV;
                     s_d.acc_rdata[15:0] = mem_port_pkg::ARCH_CODE;
                  end
                  mem_port_pkg::OFS_CAP1, mem_port_pkg::OFS_CAP2: begin
                     s_d.acc_rdata = mem_port_pkg::CAP_VALUE;
                  end
                  mem_port_pkg::OFS_CAPM: begin
                     s_d.acc_rdata = mem_port_pkg::CAP_VALUE;
                     s_d.acc_rdata[mem_port_pkg::CLASS_SUB_LSB +: 4] =
                        mem_port_pkg::CLASS_SUB;
                     s_d.acc_rdata[3:0] = mem_port_pkg::CLASS_MAJOR;
                  end
                  mem_port_pkg::OFS_WIN: begin
                     s_d.acc_done = 1'b0;
                     if (i_acc_write) begin
                        s_d.wdata[s_q.seq] = i_acc_wdata;
                        if ({1'b0, s_q.seq} == last) begin
                           s_d.st = S_MEM;
                        end else begin
                           s_d.seq = s_q.seq + 3'h1;
                           s_d.acc_done = 1'b1;
                        end
                     end else if (s_q.seq == 3'h0) begin
                        s_d.st = S_MEM;
                     end else begin
                        s_d.st = S_FETCH;
                     end
                     if (s_d.st == S_MEM) begin
                        s_d.mem_req   = 1'b1;
                        s_d.mem_write = i_acc_write;
                        s_d.mem_addr  = s_q.xfer_addr;
                        s_d.mem_size  = s_q.ctl_size;
                        s_d.mem_strb  = lane_mask(s_q.ctl_size, s_q.xfer_addr[1:0]);
                     end
                  end
                  default: begin
                     s_d.acc_rdata = 32'h0;
                  end
               endcase
            end
         end
         S_MEM: begin
            if (i_mem_done) begin
               s_d.mem_req  = 1'b0;
               s_d.acc_done = 1'b1;
               s_d.st       = S_IDLE;
               s_d.seq      = 3'h0;
               if (!s_q.mem_write) begin
                  s_d.acc_rdata = i_mem_rdata[31:0];
                  if (last != 4'h0) begin
                     s_d.seq = 3'h1;
                  end
               end
               if ((s_q.mem_write || last == 4'h0) && s_q.ctl_step != mem_port_pkg::STEP_OFF) begin
                  s_d.xfer_addr = s_q.xfer_addr + 32'(bytes_of(s_q.ctl_size));
               end
            end
         end
         S_FETCH: begin
            s_d.acc_rdata = rd_word;
            s_d.acc_done  = 1'b1;
            s_d.st        = S_IDLE;
            if ({1'b0, s_q.seq} == last) begin
               s_d.seq = 3'h0;
               if (s_q.ctl_step != mem_port_pkg::STEP_OFF) begin
                  s_d.xfer_addr = s_q.xfer_addr + 32'(bytes_of(s_q.ctl_size));
               end
            end else begin
               s_d.seq = s_q.seq + 3'h1;
            end
         end
         default: begin
            s_d.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_q          <= '0;
         s_q.ctl_size <= mem_port_pkg::CTL_SIZE_RST;
         s_q.ctl_step <= mem_port_pkg::CTL_STEP_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_acc_done  = s_q.acc_done;
   assign o_acc_rdata = s_q.acc_rdata;
   assign o_mem_req   = s_q.mem_req;
   assign o_mem_write = s_q.mem_write;
   assign o_mem_addr  = s_q.mem_addr;
   assign o_mem_size  = s_q.mem_size;
   assign o_mem_strb  = s_q.mem_strb;
   assign o_mem_wdata = s_q.wdata;

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // ==========================================================================
   // Register checks.
   arch_high_a: assert property (take && i_acc_addr == mem_port_pkg::OFS_ARCH |=>
      o_acc_done && o_acc_rdata[31:20] == {mem_port_pkg::ARCH_DESIGNER, 1'b1})
      else $error("identity high bits wrong");

   arch_low_a: assert property (take && i_acc_addr == mem_port_pkg::OFS_ARCH |=>
      o_acc_rdata[19:0] == {mem_port_pkg::ARCH_REV, mem_port_pkg::ARCH_CODE})
      else $error("identity low bits wrong");

   cap_main_a: assert property (take && i_acc_addr == mem_port_pkg::OFS_CAPM |=>
      o_acc_done && o_acc_rdata == 32'h0)
      else $error("main capability not zero");

   cap_ext_a: assert property (take && (i_acc_addr == mem_port_pkg::OFS_CAP1 ||
      i_acc_addr == mem_port_pkg::OFS_CAP2) |=> o_acc_rdata == 32'h0)
      else $error("extended capability not zero");

   class_low_a: assert property (take && i_acc_addr == mem_port_pkg::OFS_CAPM |=>
      o_acc_rdata[7:0] == {mem_port_pkg::CLASS_SUB, mem_port_pkg::CLASS_MAJOR})
      else $error("class field wrong");

   id_write_a: assert property (take && i_acc_write && i_acc_addr == mem_port_pkg::OFS_ARCH |=>
      s_q.xfer_addr == $past(s_q.xfer_addr) && s_q.ctl_size == $past(s_q.ctl_size))
      else $error("identity write had side effect");

   // ==========================================================================
   // Transfer checks.
   req_addr_a: assert property (s_d.st == S_MEM && s_q.st == S_IDLE |=>
      o_mem_req && o_mem_addr == $past(s_q.xfer_addr))
      else $error("transfer address wrong");

   mem_dir_a: assert property (s_d.st == S_MEM && s_q.st == S_IDLE |=>
      o_mem_write == $past(i_acc_write))
      else $error("transfer direction wrong");

   wr_data_a: assert property (take && i_acc_write && i_acc_addr == mem_port_pkg::OFS_WIN &&
      s_q.seq == 3'h0 |=> o_mem_wdata[31:0] == $past(i_acc_wdata))
      else $error("write data lost");

   wdata_hold_a: assert property (o_mem_req && $past(o_mem_req) |->
      $stable(o_mem_wdata) && $stable(o_mem_addr))
      else $error("transfer changed while requested");

   rd_data_a: assert property (load |=>
      o_acc_done && o_acc_rdata == $past(i_mem_rdata[31:0]))
      else $error("read data wrong");

   hold_done_a: assert property (o_mem_req |-> !o_acc_done)
      else $error("access done before transfer");

   byte_strb_a: assert property (s_d.st == S_MEM && s_q.st == S_IDLE &&
      s_q.ctl_size == mem_port_pkg::SZ_BYTE |=> o_mem_strb == 32'(32'h1 << $past(s_q.xfer_addr[1:0])))
      else $error("byte lane wrong");

   size_out_a: assert property (s_d.st == S_MEM && s_q.st == S_IDLE |=>
      o_mem_size == $past(s_q.ctl_size))
      else $error("transfer size wrong");

   part_write_a: assert property (take && i_acc_write && i_acc_addr == mem_port_pkg::OFS_WIN &&
      ({1'b0, s_q.seq} + 4'h1) != words_of(s_q.ctl_size) |=> !o_mem_req)
      else $error("early wide write");

   fetch_word_a: assert property (s_q.st == S_FETCH |=>
      o_acc_done && !o_mem_req && o_acc_rdata == $past(rd_word))
      else $error("buffered word wrong");

   csw_abandon_a: assert property (take && i_acc_addr == mem_port_pkg::OFS_CTRL |=>
      (s_q.seq == 3'h0 && !o_mem_req) [*2])
      else $error("sequence not abandoned");

   tar_step_a: assert property (s_q.st == S_MEM && i_mem_done && s_q.mem_write &&
      s_q.ctl_step != mem_port_pkg::STEP_OFF |=>
      s_q.xfer_addr == $past(s_q.xfer_addr) + 32'(bytes_of($past(s_q.ctl_size))))
      else $error("address not advanced");

   step_off_a: assert property (s_q.st == S_MEM && i_mem_done &&
      s_q.ctl_step == mem_port_pkg::STEP_OFF |=> s_q.xfer_addr == $past(s_q.xfer_addr))
      else $error("address moved with step off");
endmodule
`default_nettype wire

// [memory_port_data_and_ident_tb_top.sv]
// Self-checking bench for the memory port data window and identification registers.
`timescale 1ns/1ps
`default_nettype none
module memory_port_data_and_ident_tb_top;
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_type;
   localparam logic [31:0] ARCH = {11'h155, 1'b1, 4'h3, 16'h5a5a};
   localparam row_type ROWS [8] = '{'{1'b0, 12'hfbc, 32'h0, ARCH},
      '{1'b1, 12'hfbc, 32'hffff_ffff, ARCH}, '{1'b0, 12'hfbc, 32'h0, ARCH},
      '{1'b0, 12'hfc0, 32'h0, 32'h0}, '{1'b0, 12'hfc4, 32'h0, 32'h0},
      '{1'b1, 12'hfcc, 32'hffff_ffff, 32'h0}, '{1'b0, 12'hfcc, 32'h0, 32'h0},
      '{1'b0, 12'h800, 32'h0, 32'h0}};
   localparam logic [31:0] TA [3] = '{32'h103, 32'h102, 32'h100};
   localparam logic [31:0] SB [3] = '{32'h8, 32'hc, 32'hf};
   logic         clk = 1'b0;
   logic         resetn = 1'b0;
   logic         req = 1'b0;
   logic         wr = 1'b0;
   logic [11:0]  addr = 12'h0;
   logic [31:0]  wd = 32'h0;
   logic         slow = 1'b0;
   logic         done, mreq, mwr, mdone, m_wr;
   logic [31:0]  rd, maddr, mstrb, cnt, m_addr, m_strb, got, c0, base;
   logic [2:0]   msize, m_size;
   logic [255:0] mwdata, mrdata, m_wdata;
   int           bad_count = 0;
   int           checks_done = 0;
   int           n;

   always #2.5 clk = ~clk;

   mem_port_window dut (.i_clk(clk), .i_resetn(resetn), .i_acc_req(req), .i_acc_write(wr),
      .i_acc_addr(addr), .i_acc_wdata(wd), .o_acc_done(done), .o_acc_rdata(rd), .o_mem_req(mreq),
      .o_mem_write(mwr), .o_mem_addr(maddr), .o_mem_size(msize), .o_mem_strb(mstrb),
      .o_mem_wdata(mwdata), .i_mem_done(mdone), .i_mem_rdata(mrdata));
   mem_model mem (.i_clk(clk), .i_resetn(resetn), .i_req(mreq), .i_write(mwr), .i_addr(maddr),
      .i_size(msize), .i_strb(mstrb), .i_wdata(mwdata), .i_slow(slow), .o_done(mdone),
      .o_rdata(mrdata), .o_count(cnt), .o_addr(m_addr), .o_size(m_size), .o_strb(m_strb),
      .o_wdata(m_wdata), .o_write(m_wr));

   // ==========================================================================
   // Comparison, verdict and register access.
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus_op(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req  <= 1'b1;
      wr   <= w;
      addr <= a;
      wd   <= d;
      @(posedge clk);
      req <= 1'b0;
      repeat (100) begin
         @(posedge clk);
         if (done === 1'b1) break;
      end
      got = rd;
      if (done !== 1'b1) begin
         bad_count++;
         final_report();
      end
   endtask

   // ==========================================================================
   // Table of identification accesses, then sized and sequenced transfers.
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      foreach (ROWS[i]) begin
         bus_op(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         chk(got, ROWS[i].e, "ident");
      end
      for (int s = 0; s < 3; s++) begin
         slow <= s[0];
         bus_op(1'b1, 12'h000, 32'(s));
         bus_op(1'b1, 12'h004, TA[s]);
         c0 = cnt;
         bus_op(1'b1, 12'h00c, 32'h8421_c3a5);
         chk(cnt - c0, 32'h1, "single count");
         chk(m_addr, TA[s], "single addr");
         chk(m_strb, SB[s], "single strb");
         chk(32'(m_size), 32'(s), "single size");
         chk(m_wdata[31:0], 32'h8421_c3a5, "single wdata");
         bus_op(1'b0, 12'h00c, 32'h0);
         chk(cnt - c0, 32'h2, "read count");
         chk(32'(m_wr), 32'h0, "read dir");
         if (s == 2) chk(got, 32'h100, "word read");
         bus_op(1'b0, 12'h004, 32'h0);
         chk(got, TA[s], "addr held");
      end
      slow <= 1'b0;
      for (int s = 3; s < 6; s++) begin
         n = 1 << (s - 2);
         bus_op(1'b1, 12'h000, 32'h10 | 32'(s));
         bus_op(1'b1, 12'h004, 32'h200);
         c0 = cnt;
         for (int k = 0; k < n; k++) begin
            bus_op(1'b1, 12'h00c, 32'ha000_0000 + 32'(k));
            chk(cnt - c0, 32'(k == n - 1), "last write stores");
         end
         for (int k = 0; k < n; k++) begin
            chk(m_wdata[32*k +: 32], 32'ha000_0000 + 32'(k), "wide wdata");
         end
         chk(m_strb, 32'hffff_ffff >> (32 - (1 << s)), "wide strb");
         chk(m_addr, 32'h200, "wide addr");
         base = 32'h200 + 32'(1 << s);
         bus_op(1'b0, 12'h004, 32'h0);
         chk(got, base, "addr step");
         c0 = cnt;
         for (int k = 0; k < n; k++) begin
            bus_op(1'b0, 12'h00c, 32'h0);
            chk(got, base + 32'(k) * 32'h0101_0101, "wide read");
            chk(cnt - c0, 32'h1, "first read fetches");
         end
      end
      bus_op(1'b1, 12'h000, 32'h3);
      c0 = cnt;
      bus_op(1'b1, 12'h00c, 32'hdead_0001);
      bus_op(1'b0, 12'h000, 32'h0);
      bus_op(1'b1, 12'h00c, 32'h1111_1111);
      chk(cnt - c0, 32'h0, "abandoned write");
      bus_op(1'b1, 12'h00c, 32'h2222_2222);
      chk(cnt - c0, 32'h1, "new sequence");
      chk(m_wdata[63:32], 32'h2222_2222, "new sequence data");
      chk(m_wdata[31:0], 32'h1111_1111, "new sequence low");
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(mreq), 32'h0, "idle in reset");
      resetn <= 1'b1;
      bus_op(1'b0, 12'h000, 32'h0);
      chk(got, 32'h0, "control reset");
      bus_op(1'b0, 12'h004, 32'h0);
      chk(got, 32'h0, "address reset");
      final_report();
   end
endmodule
`default_nettype wire

// [word_store.sv]
// Eight-word store holding one wide memory read for word-by-word return.
`timescale 1ns/1ps
`default_nettype none
module word_store (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_load,
   input  wire logic [255:0] i_load_data,
   input  wire logic [2:0]   i_rd_idx,
   output logic      [31:0]  o_rd_word
);
   typedef struct packed {
      logic [7:0][31:0] words;
      logic [31:0]      rd;
   } store_type;

   store_type s_q;
   store_type s_d;

   // ==========================================================================
   // Whole-line load and registered word read.
   always_comb begin
      s_d = s_q;
      if (i_load) begin
         s_d.words = i_load_data;
      end
      s_d.rd = s_q.words[i_rd_idx];
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rd_word = s_q.rd;
endmodule
`default_nettype wire
